//--- rtl/bct_core.sv
// buffered capture timer core: capture channels, accumulators, modulus counter
// assumes channel pins are asynchronous; all controls come from core_clk logic
`timescale 1ns/10ps
`default_nettype none
module bct_core (
   input  wire logic                                  core_clk,          // core clock, 100 MHz
   input  wire logic                                  srst,              // sync reset, active high
   input  wire logic [bct_pkg::NUM_CH-1:0]            chanPin,           // channel input pins
   input  wire logic [bct_pkg::NUM_CH-1:0]            chanCompareSelect, // 1 = compare, 0 = capture
   input  wire logic [bct_pkg::NUM_CH-1:0]            noOverwriteBit,    // protect full registers
   input  wire logic [2*bct_pkg::NUM_CH-1:0]          edgeSelect,        // edge kind per channel
   input  wire logic [1:0]                            delaySelect,       // noise filter length
   input  wire logic                                  latchQueueSelect,  // 1 latch, 0 queue
   input  wire logic                                  forceLatch,        // force latch pulse
   input  wire logic                                  accumSaturate,     // stop 8-bit at max
   input  wire logic [bct_pkg::NUM_PAIR-1:0]          accumPair16,       // join accumulator pair
   input  wire logic                                  timerEnable,       // main timer run
   input  wire logic [2:0]                            mainPrescale,      // divide by 2^n
   input  wire logic                                  modEnable,         // modulus counter run
   input  wire logic [1:0]                            modPrescale,       // modulus divider select
   input  wire logic                                  modPeriodic,       // 1 reload, 0 once
   input  wire logic                                  modLoadWe,         // modulus write pulse
   input  wire logic [15:0]                           modLoadValue,      // modulus write data
   input  wire logic                                  modZeroClr,        // clear zero flag
   input  wire logic [bct_pkg::NUM_CH-1:0]            rdCapStb,          // capture read pulse
   input  wire logic [bct_pkg::NUM_BUF-1:0]           rdHoldStb,         // holding read pulse
   input  wire logic [bct_pkg::NUM_CH-1:0]            flagClr,           // channel flag clear
   output logic      [bct_pkg::NUM_CH-1:0][15:0]      capVal,            // capture registers
   output logic      [bct_pkg::NUM_BUF-1:0][15:0]     holdVal,           // holding registers
   output logic      [bct_pkg::NUM_CH-1:0]            capFull,           // capture not empty
   output logic      [bct_pkg::NUM_BUF-1:0]           holdFull,          // holding not empty
   output logic      [bct_pkg::NUM_BUF-1:0][7:0]      accVal,            // accumulators
   output logic      [bct_pkg::NUM_BUF-1:0][7:0]      accHold,           // accumulator holding
   output logic      [bct_pkg::NUM_CH-1:0]            chanFlag,          // capture event flags
   output logic      [15:0]                           mainCount,         // main timer value
   output logic      [15:0]                           modCount,          // modulus counter value
   output logic                                       modZeroFlag        // modulus reached zero
);
   import bct_pkg::*;

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic edgeHit(input logic [1:0] sel, input logic prev, input logic cur);
      edgeHit = ((sel == EDGE_RISE || sel == EDGE_ANY) && !prev && cur) ||
                ((sel == EDGE_FALL || sel == EDGE_ANY) && prev && !cur);
   endfunction

   function automatic logic [6:0] dlyLen(input logic [1:0] sel);
      unique case (sel)
         2'h0: dlyLen = DLY_LEN0;
         2'h1: dlyLen = DLY_LEN1;
         2'h2: dlyLen = DLY_LEN2;
         2'h3: dlyLen = DLY_LEN3;
      endcase
   endfunction

   function automatic logic [3:0] modDivTop(input logic [1:0] sel);
      unique case (sel)
         2'h0: modDivTop = MDIV_TOP0;
         2'h1: modDivTop = MDIV_TOP1;
         2'h2: modDivTop = MDIV_TOP2;
         2'h3: modDivTop = MDIV_TOP3;
      endcase
   endfunction

   function automatic logic [7:0] accStep(input logic [7:0] acc, input logic hit, input logic sat);
      accStep = (hit && !(sat && acc == ACC_MAX)) ? acc + ACC_ONE : acc;
   endfunction

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   logic [NUM_CH-1:0]        pinS1_q, pinS2_q, filtLvl_q, filtPrev_q;
   logic [NUM_CH-1:0][6:0]   dlyCnt_q;
   logic [6:0]               mainPre_q;
   logic [15:0]              tcnt_q;
   logic [3:0]               modPre_q;
   logic [15:0]              modCount_q, modReload_q;
   logic                     modZeroFlag_q;
   logic [NUM_CH-1:0][15:0]  capVal_q;
   logic [NUM_BUF-1:0][15:0] holdVal_q;
   logic [NUM_CH-1:0]        capFull_q, chanFlag_q;
   logic [NUM_BUF-1:0]       holdFull_q;
   logic [NUM_BUF-1:0][7:0]  accVal_q, accHold_q;
   logic [NUM_CH-1:0]        chanEdge, capEv;
   logic [NUM_BUF-1:0]       accXfer;
   logic [6:0]               preMask;
   logic                     mainTick, modTick, modZeroEv, modWrZero, latchSrc, latchEv;

   // ----------------------------------------------------------------
   // input synchronisers and delay filters
   // ----------------------------------------------------------------
   // two flops per pin before any logic looks at it
   always_ff @(posedge core_clk) begin
      pinS1_q <= chanPin;
      pinS2_q <= pinS1_q;
   end

   // level accepted only after staying changed for the delay length
   always_ff @(posedge core_clk) begin
      if (srst) begin
         filtLvl_q  <= '0;
         filtPrev_q <= '0;
         dlyCnt_q   <= '0;
      end else begin
         filtPrev_q <= filtLvl_q;
         for (int i = 0; i < NUM_CH; i++) begin
            if (pinS2_q[i] == filtLvl_q[i]) begin
               dlyCnt_q[i] <= PRE_RST;
            end else if (dlyCnt_q[i] >= dlyLen(delaySelect)) begin
               filtLvl_q[i] <= pinS2_q[i]; // RULE_21
               dlyCnt_q[i]  <= PRE_RST;
            end else begin
               dlyCnt_q[i] <= dlyCnt_q[i] + 7'h01;
            end
         end
      end
   end

   // valid edges; capture only on channels set to capture
   always_comb begin
      for (int i = 0; i < NUM_CH; i++) begin
         chanEdge[i] = edgeHit(edgeSelect[2*i +: 2], filtPrev_q[i], filtLvl_q[i]);
         capEv[i]    = chanEdge[i] && !chanCompareSelect[i]; // RULE_01 RULE_02
      end
   end

   // ----------------------------------------------------------------
   // main timer
   // ----------------------------------------------------------------
   assign preMask  = PRE_FULL >> (3'h7 - mainPrescale);
   assign mainTick = timerEnable && ((mainPre_q & preMask) == preMask);

   // 7-bit prescaler feeding the 16-bit up counter
   always_ff @(posedge core_clk) begin
      if (srst) begin
         mainPre_q <= PRE_RST;
         tcnt_q    <= CNT_RST;
      end else if (timerEnable) begin
         mainPre_q <= mainPre_q + 7'h01; // RULE_20
         if (mainTick) begin
            tcnt_q <= tcnt_q + CNT_ONE;
         end
      end
   end

   // ----------------------------------------------------------------
   // modulus down-counter
   // ----------------------------------------------------------------
   assign modTick   = modEnable && (modPre_q == modDivTop(modPrescale));
   assign modZeroEv = modTick && (modCount_q == CNT_ONE) && !modLoadWe;
   assign modWrZero = modLoadWe && (modLoadValue == CNT_RST);
   assign latchSrc  = modZeroEv || modWrZero || forceLatch;
   assign latchEv   = latchQueueSelect && latchSrc; // RULE_08

   // prescaler, count, reload or stop at zero
   always_ff @(posedge core_clk) begin
      if (srst) begin
         modPre_q    <= MPRE_RST;
         modCount_q  <= CNT_RST; // RULE_24
         modReload_q <= CNT_RST;
      end else begin
         modPre_q <= (modTick || !modEnable) ? MPRE_RST : modPre_q + 4'h1; // RULE_17
         if (modLoadWe) begin
            modCount_q  <= modLoadValue;
            modReload_q <= modLoadValue;
         end else if (modZeroEv) begin
            modCount_q <= modPeriodic ? modReload_q : CNT_RST; // RULE_19
         end else if (modTick && modCount_q != CNT_RST) begin
            modCount_q <= modCount_q - CNT_ONE;
         end
      end
   end

   // zero flag, a new zero wins over a clear
   always_ff @(posedge core_clk) begin
      if (srst) begin
         modZeroFlag_q <= 1'b0;
      end else if (modZeroEv) begin
         modZeroFlag_q <= 1'b1; // RULE_18
      end else if (modZeroClr) begin
         modZeroFlag_q <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // capture and holding registers
   // ----------------------------------------------------------------
   // reads empty a register; a same-cycle event refills it only if the register was writable before the read
   always_ff @(posedge core_clk) begin
      if (srst) begin
         capVal_q   <= '0;
         holdVal_q  <= '0;
         capFull_q  <= '0; // RULE_24
         holdFull_q <= '0;
      end else begin
         for (int i = 0; i < NUM_CH; i++) begin
            if (rdCapStb[i]) begin
               capFull_q[i] <= 1'b0; // RULE_05
            end
         end
         for (int i = 0; i < NUM_BUF; i++) begin
            if (rdHoldStb[i]) begin
               holdFull_q[i] <= 1'b0; // RULE_06
            end
         end
         // plain channels
         for (int i = NUM_BUF; i < NUM_CH; i++) begin
            if (capEv[i] && (!noOverwriteBit[i] || !capFull_q[i])) begin
               capVal_q[i]  <= tcnt_q; // RULE_03 RULE_07
               capFull_q[i] <= 1'b1;
            end
         end
         // buffered channels
         for (int i = 0; i < NUM_BUF; i++) begin
            if (latchQueueSelect) begin
               if (latchEv && (!noOverwriteBit[i] || !holdFull_q[i])) begin
                  holdVal_q[i]  <= capVal_q[i]; // RULE_08 RULE_09 RULE_10
                  holdFull_q[i] <= capFull_q[i];
                  capFull_q[i]  <= 1'b0;
               end
               if (capEv[i] && (!noOverwriteBit[i] || !capFull_q[i])) begin
                  capVal_q[i]  <= tcnt_q; // RULE_04 RULE_09 RULE_10
                  capFull_q[i] <= 1'b1;
               end
            end else if (capEv[i]) begin
               if (!noOverwriteBit[i] || (capFull_q[i] && !holdFull_q[i])) begin
                  holdVal_q[i]  <= capVal_q[i]; // RULE_11 RULE_10
                  holdFull_q[i] <= capFull_q[i];
                  capVal_q[i]   <= tcnt_q;
                  capFull_q[i]  <= 1'b1;
               end else if (!capFull_q[i]) begin
                  capVal_q[i]  <= tcnt_q; // RULE_10
                  capFull_q[i] <= 1'b1;
               end
            end
         end
      end
   end

   // channel flags, an event wins over a clear
   always_ff @(posedge core_clk) begin
      if (srst) begin
         chanFlag_q <= '0;
      end else begin
         chanFlag_q <= (chanFlag_q & ~flagClr) | capEv; // RULE_23
      end
   end

   // ----------------------------------------------------------------
   // pulse accumulators
   // ----------------------------------------------------------------
   always_comb begin
      for (int i = 0; i < NUM_BUF; i++) begin
         accXfer[i] = latchEv || (!latchQueueSelect && rdHoldStb[i]); // RULE_12 RULE_16
      end
   end

   // each pair counts alone or as one 16-bit counter on its odd channel
   always_ff @(posedge core_clk) begin
      if (srst) begin
         accVal_q  <= '0; // RULE_24
         accHold_q <= '0;
      end else begin
         for (int p = 0; p < NUM_PAIR; p++) begin
            if (accumPair16[p]) begin
               if (accXfer[2*p] || accXfer[2*p+1]) begin
                  accHold_q[2*p]   <= accVal_q[2*p]; // RULE_15
                  accHold_q[2*p+1] <= accVal_q[2*p+1];
                  accVal_q[2*p]    <= chanEdge[2*p+1] ? ACC_ONE : ACC_RST;
                  accVal_q[2*p+1]  <= ACC_RST;
               end else if (chanEdge[2*p+1]) begin
                  {accVal_q[2*p+1], accVal_q[2*p]} <= {accVal_q[2*p+1], accVal_q[2*p]} + CNT_ONE;
               end
            end else begin
               for (int k = 2*p; k < 2*p+2; k++) begin
                  if (accXfer[k]) begin
                     accHold_q[k] <= accVal_q[k]; // RULE_16 RULE_12
                     accVal_q[k]  <= chanEdge[k] ? ACC_ONE : ACC_RST;
                  end else begin
                     accVal_q[k] <= accStep(accVal_q[k], chanEdge[k], accumSaturate); // RULE_13 RULE_14
                  end
               end
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   // whole 16-bit words are presented at once
   assign capVal      = capVal_q; // RULE_22 RULE_23
   assign holdVal     = holdVal_q;
   assign capFull     = capFull_q;
   assign holdFull    = holdFull_q;
   assign accVal      = accVal_q;
   assign accHold     = accHold_q;
   assign chanFlag    = chanFlag_q;
   assign mainCount   = tcnt_q;
   assign modCount    = modCount_q;
   assign modZeroFlag = modZeroFlag_q;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   AST_CMP_NO_CAPT: assert property (@(posedge core_clk) disable iff (srst) // RULE_02
      chanCompareSelect[6] |=> $stable(capVal_q[6])) else $error("compare channel captured");
   AST_UNBUF_OVW: assert property (@(posedge core_clk) disable iff (srst) // RULE_07
      capEv[4] && !noOverwriteBit[4] |=> capVal_q[4] == $past(tcnt_q)) else $error("capture lost");
   AST_NOVW_KEEP: assert property (@(posedge core_clk) disable iff (srst) // RULE_07
      noOverwriteBit[5] && capFull_q[5] && !rdCapStb[5] |=> $stable(capVal_q[5]))
      else $error("full capture overwritten");
   AST_RD_EMPTY: assert property (@(posedge core_clk) disable iff (srst) // RULE_05
      rdCapStb[5] && !capEv[5] |=> !capFull_q[5]) else $error("read left capture full");
   AST_HOLD_RD: assert property (@(posedge core_clk) disable iff (srst) // RULE_06
      rdHoldStb[0] && !capEv[0] && !latchEv |=> !holdFull_q[0]) else $error("read left holding full");
   AST_QUEUE_SHIFT: assert property (@(posedge core_clk) disable iff (srst) // RULE_11
      !latchQueueSelect && capEv[0] && !noOverwriteBit[0]
      |=> holdVal_q[0] == $past(capVal_q[0]) && capVal_q[0] == $past(tcnt_q)) else $error("queue shift wrong");
   AST_LATCH_COPY: assert property (@(posedge core_clk) disable iff (srst) // RULE_08
      latchEv && !noOverwriteBit[2] |=> holdVal_q[2] == $past(capVal_q[2])) else $error("latch copy wrong");
   AST_ACC_SAT: assert property (@(posedge core_clk) disable iff (srst) // RULE_14
      accumSaturate && !accumPair16[1] && accVal_q[2] == ACC_MAX && !accXfer[2]
      |=> accVal_q[2] == ACC_MAX) else $error("accumulator wrapped");
   AST_PA_LATCH: assert property (@(posedge core_clk) disable iff (srst) // RULE_16
      accXfer[3] && !accumPair16[1] && !chanEdge[3]
      |=> accHold_q[3] == $past(accVal_q[3]) && accVal_q[3] == ACC_RST) else $error("accumulator latch wrong");
   AST_MOD_ZERO: assert property (@(posedge core_clk) disable iff (srst) // RULE_18
      modZeroEv |=> modZeroFlag_q && modCount_q == ($past(modPeriodic) ? $past(modReload_q) : CNT_RST))
      else $error("modulus zero wrong");
   AST_FLAG_SET: assert property (@(posedge core_clk) disable iff (srst) // RULE_23
      capEv[3] |=> chanFlag_q[3] [*1] ##0 1) else $error("flag not set");
   AST_TCNT_STEP: assert property (@(posedge core_clk) disable iff (srst) // RULE_20
      mainTick |=> tcnt_q == $past(tcnt_q) + CNT_ONE) else $error("main timer did not step");
   AST_RESET_CLR: assert property (@(posedge core_clk) // RULE_24
      srst |=> capFull_q == '0 && holdFull_q == '0 && modCount_q == CNT_RST) else $error("reset incomplete");
endmodule
`default_nettype wire

//--- rtl/bct_pkg.sv
// constants for the buffered capture timer core
// assumes a single core_clk domain and a synchronous active-high reset
//
// What this block does
// RULE_01 - eight channels, capture when select bit clear
// RULE_02 - select one means compare; selects reset zero
// RULE_03 - four plain channels store timer on edge
// RULE_04 - four buffered channels add a holding register
// RULE_05 - capture empty after read or move
// RULE_06 - holding register empty after read
// RULE_07 - plain channel: overwrite unless no-overwrite and full
// RULE_08 - latch mode copies on zero, zero write, force
// RULE_09 - latch mode without no-overwrite always overwrites
// RULE_10 - no-overwrite buffered: write only empty registers
// RULE_11 - queue mode shifts capture into holding first
// RULE_12 - queue mode holding read latches, clears accumulator
// RULE_13 - four 8-bit accumulators with holding registers
// RULE_14 - saturate bit stops unpaired accumulators at maximum
// RULE_15 - accumulator pairs can form 16-bit counters
// RULE_16 - accumulator latch moves value and clears together
// RULE_17 - 16-bit modulus down-counter with 4-bit prescaler
// RULE_18 - modulus zero raises periodic event flag
// RULE_19 - modulus latching periodic or only once
// RULE_20 - main 16-bit timer with 7-bit prescaler
// RULE_21 - selectable delay filters reject input noise
// RULE_22 - software reads 16-bit values as words
// RULE_23 - capture sets channel flag; values readable
// RULE_24 - reset clears all state except the pin synchronisers, marks registers empty
package bct_pkg;
   // ----------------------------------------------------------------
   // sizes
   // ----------------------------------------------------------------
   localparam int          NUM_CH   = 8;
   localparam int          NUM_BUF  = 4;
   localparam int          NUM_PAIR = 2;
   // ----------------------------------------------------------------
   // reset values and limits
   // ----------------------------------------------------------------
   localparam logic [15:0] CNT_RST  = 16'h0000;
   localparam logic [15:0] CNT_ONE  = 16'h0001;
   localparam logic [7:0]  ACC_RST  = 8'h00;
   localparam logic [7:0]  ACC_MAX  = 8'hFF;
   localparam logic [7:0]  ACC_ONE  = 8'h01;
   localparam logic [6:0]  PRE_RST  = 7'h00;
   localparam logic [6:0]  PRE_FULL = 7'h7F;
   localparam logic [3:0]  MPRE_RST = 4'h0;
   // ----------------------------------------------------------------
   // edge selection encoding, two bits per channel
   // ----------------------------------------------------------------
   localparam logic [1:0]  EDGE_OFF  = 2'h0;
   localparam logic [1:0]  EDGE_RISE = 2'h1;
   localparam logic [1:0]  EDGE_FALL = 2'h2;
   localparam logic [1:0]  EDGE_ANY  = 2'h3;
   // ----------------------------------------------------------------
   // delay filter lengths in core_clk cycles
   // ----------------------------------------------------------------
   localparam logic [6:0]  DLY_LEN0 = 7'h00;
   localparam logic [6:0]  DLY_LEN1 = 7'h04;
   localparam logic [6:0]  DLY_LEN2 = 7'h10;
   localparam logic [6:0]  DLY_LEN3 = 7'h40;
   // ----------------------------------------------------------------
   // modulus prescaler terminal counts (divide 1, 4, 8, 16)
   // ----------------------------------------------------------------
   localparam logic [3:0]  MDIV_TOP0 = 4'h0;
   localparam logic [3:0]  MDIV_TOP1 = 4'h3;
   localparam logic [3:0]  MDIV_TOP2 = 4'h7;
   localparam logic [3:0]  MDIV_TOP3 = 4'hF;
endpackage

//--- tb/bct_pin_model.sv
// pin model: the external inputs wired to the channel pins
// assumes toggle requests are set between rising clock edges
`timescale 1ns/10ps
`default_nettype none
module bct_pin_model (
   input  wire logic       core_clk,  // core clock
   input  wire logic [7:0] toggleReq, // one-cycle toggle request per pin
   output var  logic [7:0] chanPin    // external channel pins
);
   // pins idle low; each request inverts its pin once, one edge per request
   initial chanPin = 8'h00;
   always @(posedge core_clk) begin
      chanPin <= chanPin ^ toggleReq;
   end
endmodule
`default_nettype wire

//--- tb/buffered_capture_timer_tb.sv
// testbench for the buffered capture timer core, edges from the pin model
// assumes bct_pkg, bct_core and bct_pin_model are compiled first
`timescale 1ns/10ps
`default_nettype none
// whole 16-bit values are compared in one step
`define CHK(a,e) begin n_tests++; if ((a) !== (e)) begin num_errors++; $display("mismatch %0t got %h exp %h", $time, a, e); end end
module buffered_capture_timer_tb;
   import bct_pkg::*;
   logic                    core_clk = 1'b0, srst = 1'b1, latchQueueSelect = 1'b0, forceLatch = 1'b0;
   logic                    accumSaturate = 1'b0, timerEnable = 1'b0, modEnable = 1'b0, modPeriodic = 1'b1;
   logic                    modLoadWe = 1'b0, modZeroClr = 1'b0, modZeroFlag;
   logic [7:0]              toggleReq = '0, chanCompareSelect = '0, noOverwriteBit = '0, rdCapStb = '0;
   logic [7:0]              flagClr = '0, chanPin, capFull, chanFlag;
   logic [3:0]              rdHoldStb = '0, holdFull;
   logic [1:0]              accumPair16 = '0, delaySelect = '0, modPrescale = '0;
   logic [2:0]              mainPrescale = '0;
   logic [15:0]             modLoadValue = '0, edgeSelect = {NUM_CH{EDGE_ANY}}, t1, t2, mainCount, modCount;
   logic [NUM_CH-1:0][15:0] capVal;
   logic [3:0][15:0]        holdVal;
   logic [3:0][7:0]         accVal, accHold;
   int                      num_errors = 0, n_tests = 0, cycles = 0;
   // ---------------------------------------------------------------
   // clock, partner and design
   // ---------------------------------------------------------------
   always #5 core_clk = ~core_clk;
   bct_pin_model i_pins (.core_clk, .toggleReq, .chanPin);
   bct_core i_dut (.core_clk, .srst, .chanPin, .chanCompareSelect, .noOverwriteBit,
      .edgeSelect, .delaySelect, .latchQueueSelect, .forceLatch,
      .accumSaturate, .accumPair16, .timerEnable, .mainPrescale, .modEnable,
      .modPrescale, .modPeriodic, .modLoadWe, .modLoadValue, .modZeroClr, .rdCapStb,
      .rdHoldStb, .flagClr, .capVal, .holdVal, .capFull, .holdFull, .accVal, .accHold,
      .chanFlag, .mainCount, .modCount, .modZeroFlag);
   // ---------------------------------------------------------------
   // helper tasks; hit, run and waitZero are entered just after a falling edge, stop_test also from the hang guard at a rising edge
   // ---------------------------------------------------------------
   task automatic cyc(input int n);
      repeat (n) @(negedge core_clk);
   endtask
   // one edge on each masked pin, then time for it to be captured
   task automatic hit(input logic [7:0] m);
      toggleReq = m;
      cyc(1);
      toggleReq = '0;
      cyc(8);
   endtask
   // main timer runs for a while, then stands still
   task automatic run(input int n);
      timerEnable = 1'b1;
      cyc(n);
      timerEnable = 1'b0;
      cyc(2);
   endtask
   task automatic waitZero;
      for (int i = 0; i < 40 && modZeroFlag !== 1'b1; i++) cyc(1);
   endtask
   task automatic stop_test;
      $display("errors %0d checks %0d", num_errors, n_tests);
      if (num_errors == 0 && n_tests > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // hang guard, about five times the expected run
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 27000) begin
         num_errors++;
         stop_test();
      end
   end
   // ---------------------------------------------------------------
   // test sequence
   // ---------------------------------------------------------------
   initial begin
      cyc(12);
      srst = 1'b0;
      cyc(2);
      `CHK({capFull, holdFull, chanFlag, modZeroFlag, mainCount}, 37'h0)
      // plain capture, flag set and cleared; compare channel ignores pin
      run(5);
      hit(8'h10);
      `CHK(capVal[4], mainCount)
      `CHK({capFull[4], chanFlag[4]}, 2'b11)
      flagClr = 8'h10;
      cyc(1);
      flagClr = '0;
      chanCompareSelect = 8'h40;
      hit(8'h40);
      `CHK({capFull[6], chanFlag[6], chanFlag[4]}, 3'b000)
      chanCompareSelect = '0;
      hit(8'h40);
      `CHK(capFull[6], 1'b1)
      // plain channel with overwrite protection
      noOverwriteBit = 8'h28;
      hit(8'h20);
      t1 = mainCount;
      run(5);
      hit(8'h20);
      `CHK(capVal[5], t1)
      rdCapStb = 8'h20;
      cyc(1);
      rdCapStb = '0;
      cyc(1);
      `CHK(capFull[5], 1'b0)
      hit(8'h20);
      `CHK(capVal[5], mainCount)
      // queue mode: shift into holding, read moves accumulator
      run(3);
      t1 = mainCount;
      hit(8'h01);
      run(3);
      hit(8'h01);
      `CHK({holdVal[0], capVal[0]}, {t1, mainCount})
      `CHK(accVal[0], 8'h02)
      rdHoldStb = 4'h1;
      cyc(1);
      rdHoldStb = '0;
      cyc(1);
      `CHK(accHold[0], 8'h02)
      `CHK({holdFull[0], accVal[0]}, 9'h0)
      // queue mode with protection: third capture dropped
      hit(8'h08);
      t1 = mainCount;
      run(3);
      hit(8'h08);
      t2 = mainCount;
      run(3);
      hit(8'h08);
      `CHK({holdVal[3], capVal[3], holdFull[3]}, {t1, t2, 1'b1})
      // latch mode: forced latch, then zero write overwrites holding
      latchQueueSelect = 1'b1;
      run(2);
      hit(8'h02);
      t1 = mainCount;
      forceLatch = 1'b1;
      cyc(1);
      forceLatch = 1'b0;
      cyc(1);
      `CHK({holdVal[1], capFull[1], holdFull[1]}, {t1, 2'b01})
      `CHK({accHold[1], accVal[1]}, 16'h0100)
      run(4);
      hit(8'h02);
      modLoadWe = 1'b1;
      cyc(1);
      modLoadWe = 1'b0;
      cyc(1);
      `CHK(holdVal[1], mainCount)
      // saturating accumulator
      accumSaturate = 1'b1;
      repeat (260) hit(8'h04);
      `CHK(accVal[2], ACC_MAX)
      // modulus counter: periodic reload, then once
      modLoadValue = 16'h0005;
      modLoadWe = 1'b1;
      cyc(1);
      modLoadWe = 1'b0;
      modEnable = 1'b1;
      waitZero();
      `CHK({modZeroFlag, modCount}, 17'h10005)
      modPeriodic = 1'b0;
      modZeroClr = 1'b1;
      cyc(1);
      modZeroClr = 1'b0;
      waitZero();
      cyc(10);
      `CHK({modZeroFlag, modCount}, 17'h10000)
      // modulus prescaler at divide by 16: one step in twenty cycles
      modPrescale = 2'h3;
      modLoadValue = 16'h0002;
      modLoadWe = 1'b1;
      modZeroClr = 1'b1;
      cyc(1);
      modLoadWe = 1'b0;
      modZeroClr = 1'b0;
      cyc(20);
      `CHK({modZeroFlag, modCount}, 17'h00001)
      modEnable = 1'b0;
      // delay filter: short glitch dropped, rise ignored, fall captured
      delaySelect = 2'h1;
      edgeSelect[15:14] = EDGE_FALL;
      toggleReq = 8'h80;
      cyc(2);
      toggleReq = '0;
      cyc(8);
      hit(8'h80);
      `CHK({capFull[7], chanFlag[7]}, 2'b00)
      hit(8'h80);
      `CHK(capFull[7], 1'b1)
      // paired accumulators count past 255 on the odd channel
      accumPair16 = 2'h1;
      repeat (257) hit(8'h02);
      `CHK({accVal[1], accVal[0]}, 16'h0101)
      forceLatch = 1'b1;
      cyc(1);
      forceLatch = 1'b0;
      cyc(1);
      `CHK({accHold[1], accHold[0], accVal[1], accVal[0]}, 32'h01010000)
      // main prescaler at full seven bits: two steps in 256 cycles
      mainPrescale = 3'h7;
      run(256);
      `CHK(mainCount, 16'h001E)
      stop_test();
   end
endmodule
`undef CHK
`default_nettype wire
